/* File: include/adc_ctrl_pkg.sv */
// Purpose: constants for the converter control block
// Assumes: APB, 32-bit data, one register per aligned word
// Notes:   offsets are byte addresses
package adc_ctrl_pkg;
   // ***************************************************
   // register map
   // ***************************************************
   localparam logic [7:0] off_clock   = 8'h00;
   localparam logic [7:0] off_ref     = 8'h04;
   localparam logic [7:0] off_channel = 8'h08;
   localparam logic [7:0] off_start   = 8'h0c;
   localparam logic [7:0] off_result  = 8'h10;
   localparam logic [7:0] off_irq     = 8'h14;
   localparam logic [7:0] off_ain_en  = 8'h18;
   localparam logic [7:0] off_status  = 8'h1c;
   // ***************************************************
   // field positions
   // ***************************************************
   localparam int pos_gate     = 3;
   localparam int pos_ref_on   = 0;
   localparam int pos_handover = 1;
   localparam int pos_flag     = 0;
   localparam int pos_enable   = 1;
   localparam int pos_prio     = 4;
   localparam int pos_cpu_lvl  = 6;
   localparam int pos_busy     = 0;
   // ***************************************************
   // reset values and timing
   // ***************************************************
   localparam logic [2:0] rst_divider = 3'h0;
   localparam logic [7:0] rst_ain_en  = 8'h00;
   localparam logic [23:0] irq_vector = 24'h000026;
   localparam int sample_delay_cycles = 4;
   localparam int sample_cycles       = 2;
   localparam int result_bits         = 10;
   typedef enum logic [3:0] {
      st_idle   = 4'b0001,
      st_delay  = 4'b0010,
      st_sample = 4'b0100,
      st_conv   = 4'b1000
   } conv_state_t;
endpackage

/* File: src/adc_conversion_control.sv */
// Purpose: conversion clock, reference drive, channel, start, result and completion flag of a 10-bit SAR converter
// Assumes: APB slave on pclk; comparator result is a level from the analog side
// Notes:   conversion steps advance on the gated divided clock tick
//
// Notes on behaviour
// - divider select: 1xx /16, else /8,/4,/2,/1
// - clock passes only while gate bit set
// - no clock while oscillator stopped
// - reference-on 1 drives eligible pins low
// - all eligible pins follow one control bit
// - handover lets touch controller drive reference
// - channel field binary, 0 to 7
// - start write selects channel, launches conversion
// - sample after start delay, then 10-bit SAR
// - result bit 0 LSB, bit 9 MSB
// - finish and interrupt at result load
// - completion flag set regardless of enable
// - irq when flag, enable and priority above level
// - enable zero suppresses irq, flag still set
// - writing 1 clears completion flag
// - completion vector is 000026H
// - analog enable bit switches pin to analog
//
// The implementer's own choices: the APB slave port and the address map.
`timescale 1ns/1ps
module adc_conversion_control
   import adc_ctrl_pkg::*;
#(
   parameter int sar_bits = result_bits
) (
   input  wire logic                pclk,
   input  wire logic                presetn,
   input  wire logic                psel,
   input  wire logic                penable,
   input  wire logic                pwrite,
   input  wire logic [7:0]          paddr,
   input  wire logic [31:0]         pwdata,
   output logic                     pready,
   output logic [31:0]              prdata,
   output logic                     pslverr,
   input  wire logic                high_speed_oscillator,
   input  wire logic                comparator_high,
   input  wire logic                touch_active,
   input  wire logic                touch_reference_on,
   input  wire logic [7:0]          port_output_mode,
   input  wire logic [7:0]          port_data,
   input  wire logic [1:0]          cpu_irq_level,
   output logic                     conv_clock,
   output logic [2:0]               analog_mux_select,
   output logic                     sample_hold,
   output logic [sar_bits-1:0]      dac_code,
   output logic [7:0]               analog_input_enable,
   output logic [7:0]               shared_port_pins_low,
   output logic                     cpu_irq,
   output logic [23:0]              cpu_irq_vector
);
   // ***************************************************
   // state
   // ***************************************************
   logic [2:0]          conv_clock_divider_select;
   logic                conv_clock_gate;
   logic                reference_on_control;
   logic                reference_handover_to_touch;
   logic [2:0]          input_channel_select;
   logic                completion_factor_flag;
   logic                completion_irq_enable;
   logic [1:0]          irq_priority;
   logic [sar_bits-1:0] result;
   logic [sar_bits-1:0] trial;
   logic [3:0]          bit_idx;
   logic [3:0]          step_count;
   logic [3:0]          div_count;
   logic                tick;
   logic                osc_meta;
   logic                osc_run;
   logic                cmp_meta;
   logic                cmp_sync;
   logic [1:0]          lvl_meta;
   logic [1:0]          lvl_sync;
   conv_state_t         state;
   logic                wr;
   logic                start_wr;
   logic                done;

   function automatic logic [3:0] div_limit(input logic [2:0] sel);
      if (sel[2])
         div_limit = 4'hf;
      else if (sel == 3'h3)
         div_limit = 4'h7;
      else if (sel == 3'h2)
         div_limit = 4'h3;
      else if (sel == 3'h1)
         div_limit = 4'h1;
      else
         div_limit = 4'h0;
   endfunction

   assign wr       = psel && penable && pwrite;
   assign start_wr = wr && paddr == off_start && state == st_idle;
   assign done     = state == st_conv && tick && bit_idx == 4'h0;
   // ***************************************************
   // synchronisers
   // ***************************************************
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         osc_meta <= 1'b0;
         osc_run  <= 1'b0;
         cmp_meta <= 1'b0;
         cmp_sync <= 1'b0;
         lvl_meta <= 2'h0;
         lvl_sync <= 2'h0;
      end else begin
         osc_meta <= high_speed_oscillator;
         osc_run  <= osc_meta;
         cmp_meta <= comparator_high;
         cmp_sync <= cmp_meta;
         lvl_meta <= cpu_irq_level;
         lvl_sync <= lvl_meta;
      end
   end
   // ***************************************************
   // conversion clock divider and gate
   // ***************************************************
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         div_count  <= 4'h0;
         tick       <= 1'b0;
         conv_clock <= 1'b0;
      end else if (!conv_clock_gate || !osc_run) begin
         div_count  <= 4'h0;
         tick       <= 1'b0;
         conv_clock <= 1'b0;
      end else if (div_count >= div_limit(conv_clock_divider_select)) begin
         div_count  <= 4'h0;
         tick       <= 1'b1;
         conv_clock <= ~conv_clock;
      end else begin
         div_count  <= div_count + 4'h1;
         tick       <= 1'b0;
      end
   end
   // ***************************************************
   // registers
   // ***************************************************
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         conv_clock_divider_select   <= rst_divider;
         conv_clock_gate             <= 1'b0;
         reference_on_control        <= 1'b0;
         reference_handover_to_touch <= 1'b0;
         input_channel_select        <= 3'h0;
         completion_irq_enable       <= 1'b0;
         irq_priority                <= 2'h0;
         analog_input_enable         <= rst_ain_en;
      end else if (wr) begin
         if (paddr == off_clock) begin
            conv_clock_divider_select <= pwdata[2:0];
            conv_clock_gate           <= pwdata[pos_gate];
         end else if (paddr == off_ref) begin
            reference_on_control        <= pwdata[pos_ref_on];
            reference_handover_to_touch <= pwdata[pos_handover];
         end else if (paddr == off_channel) begin
            input_channel_select <= pwdata[2:0];
         end else if (paddr == off_irq) begin
            completion_irq_enable <= pwdata[pos_enable];
            irq_priority          <= pwdata[pos_prio +: 2];
         end else if (paddr == off_ain_en) begin
            analog_input_enable <= pwdata[7:0];
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn)
         completion_factor_flag <= 1'b0;
      else if (done)
         completion_factor_flag <= 1'b1;
      else if (wr && paddr == off_irq && pwdata[pos_flag])
         completion_factor_flag <= 1'b0;
   end
   // ***************************************************
   // conversion sequencer
   // ***************************************************
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state             <= st_idle;
         step_count        <= 4'h0;
         bit_idx           <= 4'h0;
         trial             <= '0;
         result            <= '0;
         analog_mux_select <= 3'h0;
         sample_hold       <= 1'b0;
         dac_code          <= '0;
      end else begin
         case (state)
            st_idle: begin
               if (start_wr) begin
                  analog_mux_select <= input_channel_select;
                  step_count        <= 4'h0;
                  state             <= st_delay;
               end
            end
            st_delay: begin
               if (tick) begin
                  if (step_count == 4'(sample_delay_cycles - 1)) begin
                     step_count  <= 4'h0;
                     sample_hold <= 1'b1;
                     state       <= st_sample;
                  end else
                     step_count <= step_count + 4'h1;
               end
            end
            st_sample: begin
               if (tick) begin
                  if (step_count == 4'(sample_cycles - 1)) begin
                     sample_hold <= 1'b0;
                     bit_idx     <= 4'(sar_bits - 1);
                     trial       <= '0;
                     dac_code    <= {1'b1, {(sar_bits-1){1'b0}}};
                     state       <= st_conv;
                  end else
                     step_count <= step_count + 4'h1;
               end
            end
            st_conv: begin
               if (tick) begin
                  trial[bit_idx] <= cmp_sync;
                  if (bit_idx == 4'h0) begin
                     result <= {trial[sar_bits-1:1], cmp_sync};
                     state  <= st_idle;
                  end else begin
                     bit_idx  <= bit_idx - 4'h1;
                     dac_code <= (trial | ({{(sar_bits-1){1'b0}}, cmp_sync} << bit_idx))
                                 | ({{(sar_bits-1){1'b0}}, 1'b1} << (bit_idx - 4'h1));
                  end
               end
            end
            default: state <= st_idle;
         endcase
      end
   end
   // ***************************************************
   // reference drive and interrupt
   // ***************************************************
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         shared_port_pins_low <= 8'h00;
         cpu_irq              <= 1'b0;
         cpu_irq_vector       <= irq_vector;
      end else begin
         // eligible pins: output mode, data 1, not analog input
         shared_port_pins_low <= {8{reference_handover_to_touch && touch_active ? touch_reference_on
                                    : reference_on_control}}
                                 & port_output_mode & port_data & ~analog_input_enable;
         cpu_irq <= (completion_factor_flag || done) && completion_irq_enable
                    && irq_priority > lvl_sync;
         cpu_irq_vector <= irq_vector;
      end
   end
   // ***************************************************
   // apb read
   // ***************************************************
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata  <= 32'h0;
         pready  <= 1'b0;
         pslverr <= 1'b0;
      end else begin
         pready  <= psel && !penable;
         pslverr <= 1'b0;
         prdata  <= 32'h0;
         if (psel && !penable && !pwrite) begin
            if (paddr == off_clock)
               prdata <= {28'h0, conv_clock_gate, conv_clock_divider_select};
            else if (paddr == off_ref)
               prdata <= {30'h0, reference_handover_to_touch, reference_on_control};
            else if (paddr == off_channel)
               prdata <= {29'h0, input_channel_select};
            else if (paddr == off_result)
               prdata <= {{(32-sar_bits){1'b0}}, result};
            else if (paddr == off_irq)
               prdata <= {24'h0, lvl_sync, irq_priority, 2'h0, completion_irq_enable, completion_factor_flag};
            else if (paddr == off_ain_en)
               prdata <= {24'h0, analog_input_enable};
            else if (paddr == off_status)
               prdata <= {31'h0, state != st_idle};
         end
      end
   end
   // ***************************************************
   // checks
   // ***************************************************
   property p_no_clock_gated;
      @(posedge pclk) disable iff (!presetn) !conv_clock_gate |=> !tick;
   endproperty
   a_no_clock_gated: assert property (p_no_clock_gated) else $error("tick while gate off");
   property p_no_clock_osc;
      @(posedge pclk) disable iff (!presetn) !osc_run |=> !tick;
   endproperty
   a_no_clock_osc: assert property (p_no_clock_osc) else $error("tick with oscillator stopped");
   property p_flag_on_done;
      @(posedge pclk) disable iff (!presetn) done |=> completion_factor_flag && state == st_idle;
   endproperty
   a_flag_on_done: assert property (p_flag_on_done) else $error("flag not set on completion");
   property p_flag_clear;
      @(posedge pclk) disable iff (!presetn)
         wr && paddr == off_irq && pwdata[pos_flag] && !done |=> !completion_factor_flag;
   endproperty
   a_flag_clear: assert property (p_flag_clear) else $error("flag not cleared");
   property p_irq_gate;
      @(posedge pclk) disable iff (!presetn) cpu_irq |-> $past(completion_irq_enable);
   endproperty
   a_irq_gate: assert property (p_irq_gate) else $error("irq while disabled");
   property p_mux_stable;
      @(posedge pclk) disable iff (!presetn) state != st_idle && $past(state) != st_idle |-> $stable(analog_mux_select);
   endproperty
   a_mux_stable: assert property (p_mux_stable) else $error("channel moved mid-conversion");
   sequence s_start;
      start_wr;
   endsequence
   property p_start;
      @(posedge pclk) disable iff (!presetn) s_start |=> state == st_delay && analog_mux_select == $past(input_channel_select);
   endproperty
   a_start: assert property (p_start) else $error("start not launched");
   property p_ref_pins;
      @(posedge pclk) disable iff (!presetn)
         !reference_handover_to_touch && !reference_on_control ##1 $stable(reference_on_control) |-> shared_port_pins_low == 8'h00;
   endproperty
   a_ref_pins: assert property (p_ref_pins) else $error("pins low with reference off");
endmodule

/* File: test/analog_side_model.sv */
// Purpose: analog front end model: input multiplexer, sample/hold, comparator, reference transistor
// Assumes: comparator compares the held input (half an lsb above its level) with the trial code
// Notes:   with the reference off the comparator output is meaningless and toggles every cycle
`timescale 1ns/1ps
module analog_side_model
   import adc_ctrl_pkg::*;
(
   input  wire logic                   pclk,
   input  wire logic                   sample_hold,
   input  wire logic [2:0]             analog_mux_select,
   input  wire logic [result_bits-1:0] dac_code,
   input  wire logic [7:0]             shared_port_pins_low,
   output logic                        comparator_high
);
   localparam logic [9:0] level [8] = '{10'h000, 10'h3ff, 10'h155, 10'h2aa, 10'h001, 10'h200, 10'h1ff, 10'h3fe};
   logic [9:0] held = 10'h000;
   logic       noise = 1'b0;

   always_ff @(posedge pclk) begin
      noise <= ~noise;
   end

   always_ff @(posedge pclk) begin
      if (sample_hold) begin
         held <= level[analog_mux_select];
      end
   end

   // transistor conducts while any shared pin pulls low
   assign comparator_high = (|shared_port_pins_low) ? (held >= dac_code) : noise;
endmodule

/* File: test/tb_top.sv */
// Purpose: self-checking bench for the converter control block
// Assumes: apb answers with no wait states, conversion clock at /16 for conversions
// Notes:   channel 7 pin is kept for reference switching, channels 0 to 6 converted
`timescale 1ns/1ps
module tb_top;
   import adc_ctrl_pkg::*;
   logic        pclk = 1'b0;
   logic        presetn, psel, penable, pwrite, pready, pslverr;
   logic [7:0]  paddr;
   logic [31:0] pwdata, prdata, d;
   logic        high_speed_oscillator, comparator_high, touch_active, touch_reference_on;
   logic [7:0]  port_output_mode, port_data, analog_input_enable, shared_port_pins_low;
   logic [1:0]  cpu_irq_level;
   logic        conv_clock, sample_hold, cpu_irq;
   logic [2:0]  analog_mux_select;
   logic [9:0]  dac_code;
   logic [23:0] cpu_irq_vector;
   int          err_count = 0;
   int          comparisons = 0;

   always #2.5 pclk = ~pclk;

   adc_conversion_control adc_conversion_control_inst (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata),
      .pslverr(pslverr), .high_speed_oscillator(high_speed_oscillator), .comparator_high(comparator_high),
      .touch_active(touch_active), .touch_reference_on(touch_reference_on), .port_output_mode(port_output_mode),
      .port_data(port_data), .cpu_irq_level(cpu_irq_level), .conv_clock(conv_clock),
      .analog_mux_select(analog_mux_select), .sample_hold(sample_hold), .dac_code(dac_code),
      .analog_input_enable(analog_input_enable), .shared_port_pins_low(shared_port_pins_low),
      .cpu_irq(cpu_irq), .cpu_irq_vector(cpu_irq_vector));

   analog_side_model analog_side_model_inst (.pclk(pclk), .sample_hold(sample_hold),
      .analog_mux_select(analog_mux_select), .dac_code(dac_code),
      .shared_port_pins_low(shared_port_pins_low), .comparator_high(comparator_high));

   // ***************************************************
   // bus and check helpers
   // ***************************************************
   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      comparisons++;
      if (got !== exp) begin
         err_count++;
         $display("ERROR %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
      int n;
      n = 0;
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= wd;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1 && n < 20) begin
         @(posedge pclk);
         n++;
      end
      chk("pslverr", 0, pslverr);
      d = prdata;
      psel <= 1'b0;
      penable <= 1'b0;
      chk("apb answer", 1, n < 20);
   endtask

   task automatic wait_rise(output int n);
      n = 0;
      @(posedge pclk);
      while (conv_clock !== 1'b0 && n < 100) begin
         @(posedge pclk);
         n++;
      end
      while (conv_clock !== 1'b1 && n < 100) begin
         @(posedge pclk);
         n++;
      end
   endtask

   task automatic wrap_up;
      $display("comparisons %0d err_count %0d", comparisons, err_count);
      if (err_count == 0 && comparisons > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask

   // ***************************************************
   // scenarios
   // ***************************************************
   task automatic t_reset;
      logic [7:0] offs [8] = '{off_clock, off_ref, off_channel, off_result, off_irq, off_ain_en, off_status, 8'h20};
      chk("vector", 24'h000026, cpu_irq_vector);
      chk("pins", 0, shared_port_pins_low);
      apb(1'b1, 8'h20, 32'hffffffff);
      foreach (offs[i]) begin
         apb(1'b0, offs[i], 0);
         chk("reset read", 0, d);
      end
   endtask

   task automatic t_clock;
      logic [2:0] sels [6] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h4, 3'h7};
      int n;
      foreach (sels[i]) begin
         apb(1'b1, off_clock, {28'h0, 1'b1, sels[i]});
         wait_rise(n);
         wait_rise(n);
         chk("clock period", sels[i][2] ? 32 : 2 << sels[i], n + 1);
      end
      apb(1'b1, off_clock, 32'h4);
      wait_rise(n);
      chk("gated off", 1, n >= 100);
      apb(1'b1, off_clock, 32'hc);
      high_speed_oscillator <= 1'b0;
      wait_rise(n);
      wait_rise(n);
      chk("osc stopped", 1, n >= 100);
      high_speed_oscillator <= 1'b1;
   endtask

   task automatic t_reference;
      port_output_mode <= 8'hf0;
      port_data <= 8'hb0;
      apb(1'b1, off_ain_en, 32'h20);
      @(posedge pclk);
      chk("ain enable", 8'h20, analog_input_enable);
      apb(1'b1, off_ref, 32'h1);
      repeat (2) @(posedge pclk);
      chk("pins on", 8'h90, shared_port_pins_low);
      apb(1'b1, off_ref, 32'h0);
      repeat (2) @(posedge pclk);
      chk("pins off", 0, shared_port_pins_low);
      touch_active <= 1'b1;
      touch_reference_on <= 1'b1;
      apb(1'b1, off_ref, 32'h2);
      repeat (2) @(posedge pclk);
      chk("touch on", 8'h90, shared_port_pins_low);
      touch_reference_on <= 1'b0;
      repeat (3) @(posedge pclk);
      chk("touch off", 0, shared_port_pins_low);
      touch_active <= 1'b0;
      apb(1'b1, off_ref, 32'h0);
      repeat (2) @(posedge pclk);
      chk("general io", 0, shared_port_pins_low);
   endtask

   task automatic t_convert(input logic [2:0] ch);
      logic       en;
      logic [1:0] lvl;
      int         n;
      en = (ch != 3'h1);
      lvl = {1'b0, ch[2]};
      cpu_irq_level <= lvl;
      apb(1'b1, off_channel, {29'h0, ch});
      apb(1'b1, off_irq, {26'h0, ch[1:0], 2'h0, en, 1'b0});
      apb(1'b1, off_start, 32'h1);
      @(posedge pclk);
      chk("mux", ch, analog_mux_select);
      apb(1'b1, off_channel, {29'h0, ~ch});
      apb(1'b0, off_status, 0);
      chk("busy", 1, d[pos_busy]);
      n = 0;
      while (d[pos_busy] === 1'b1 && n < 400) begin
         apb(1'b0, off_status, 0);
         n++;
      end
      chk("conversion end", 1, n < 400);
      chk("sample hold idle", 0, sample_hold);
      chk("latched mux", ch, analog_mux_select);
      repeat (3) @(posedge pclk);
      apb(1'b0, off_result, 0);
      chk("result", analog_side_model_inst.level[ch], d);
      apb(1'b0, off_irq, 0);
      chk("flag", 1, d[pos_flag]);
      chk("cpu irq", en && (ch[1:0] > lvl), cpu_irq);
      apb(1'b1, off_irq, {26'h0, ch[1:0], 2'h0, en, 1'b1});
      apb(1'b0, off_irq, 0);
      chk("flag clear", 0, d[pos_flag]);
      repeat (2) @(posedge pclk);
      chk("irq clear", 0, cpu_irq);
   endtask

   initial begin
      presetn = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0;
      high_speed_oscillator = 1'b1;
      touch_active = 1'b0;
      touch_reference_on = 1'b0;
      port_output_mode = 8'h00;
      port_data = 8'h00;
      cpu_irq_level = 2'h0;
      repeat (3) @(posedge pclk);
      presetn <= 1'b1;
      t_reset();
      t_clock();
      t_reference();
      port_output_mode <= 8'h80;
      port_data <= 8'h80;
      apb(1'b1, off_ain_en, 32'h7f);
      apb(1'b1, off_ref, 32'h1);
      apb(1'b1, off_clock, 32'hc);
      for (int c = 0; c < 7; c++) begin
         t_convert(c[2:0]);
      end
      wrap_up();
   end

   initial begin
      #100000;
      err_count++;
      wrap_up();
   end
endmodule
